// File: hw/eewc_top.sv
// Write control, row latches and storage array of the paged data EEPROM.
//
// Function
// - Parallel enable latches the next write's row; it changes only at end or disable.
// - Setting parallel enable clears all eight row latch loaded marks.
// - Parallel cycle writes only bytes loaded since parallel enable was set.
// - Parallel enable clears itself at the end of each parallel cycle.
// - Start written without parallel enable starts nothing and stays clear.
// - Start bit sets only with program enable and parallel enable already set.
// - Control register at DFh, reset 00h, with the documented bit layout.
// - Stand-by disables the array and makes every EEPROM access meaningless.
// - Start programs the loaded row bytes together and clears itself at the end.
// - A row is eight bytes sharing A7..A3; A2..A0 pick the byte.
// - Clearing parallel enable before start abandons without touching the array.
// - Busy reads high for the whole programming cycle and clears at its end.
// - Accesses during busy other than control reads are dropped; the running cycle completes unaffected.
// - Without program enable an EEPROM write starts no cycle.
// - Unprogrammed locations read FFh.
// - Two 64-byte pages appear at 00h-3Fh, chosen by bank select.
// - Control writes are ignored while busy; only busy is readable.
// - With stand-by and busy clear an EEPROM read takes a normal read time.
// - Byte mode programs exactly one byte per write.
`timescale 1ns/1ps
`default_nettype none
module eewc_top #(
    parameter int PROG_CYCLES = eewc_pkg::PROG_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [1:0] bank_select,
    output logic [7:0] rdata,
    output logic eeprom_busy
);
    localparam int ADDR_W = $clog2(eewc_pkg::PAGES * eewc_pkg::PAGE_BYTES);

    // The busy assertion counts eight cycles and the timer has 16 bits.
    if (PROG_CYCLES < 8 || PROG_CYCLES > 65535) begin : g_bad_cycles
        $error("PROG_CYCLES must lie in 8..65535");
    end

    typedef struct packed {
        eewc_pkg::eewc_state_t state;
        logic standby;
        logic par_start;
        logic par_en;
        logic busy;
        logic prog_en;
        logic row_valid;
        logic [ADDR_W-4:0] row;
        logic [7:0] mask;
        logic [7:0][7:0] lat;
        logic [ADDR_W-1:0] baddr;
        logic [7:0] bdata;
        logic par_cyc;
        logic [15:0] cnt;
        logic [7:0] rdata;
    } eewc_regs_t;

    eewc_regs_t st_r;
    eewc_regs_t st_nxt;
    // Virgin array content; reset never touches the cells.
    // A declaration value keeps the clocked update as the only writer.
    logic [7:0] mem [eewc_pkg::PAGES * eewc_pkg::PAGE_BYTES] =
        '{default: eewc_pkg::VIRGIN};
    logic page_ok;
    logic ee_hit;
    logic ctrl_hit;
    logic done;
    logic [ADDR_W-1:0] ee_addr;

    // Decode of the paged window; a bad bank value maps nothing.
    assign page_ok = bank_select == eewc_pkg::BANK_PAGE0 ||
                     bank_select == eewc_pkg::BANK_PAGE1;
    assign ee_hit = addr < eewc_pkg::WIN_LIMIT && page_ok && !st_r.standby;
    assign ctrl_hit = addr == eewc_pkg::CTRL_ADDR;
    assign ee_addr = {bank_select[1], addr[5:0]};
    assign done = st_r.state == eewc_pkg::EEWC_PROG && st_r.cnt == 16'h0000;
    assign rdata = st_r.rdata;
    assign eeprom_busy = st_r.busy;

    // Next-state logic for control, row latches and the cycle timer.
    always_comb begin
        st_nxt = st_r;
        // Control writes: dropped entirely while a cycle runs.
        if (wr && ctrl_hit && !st_r.busy) begin
            st_nxt.standby = wdata[eewc_pkg::BIT_STANDBY];
            st_nxt.prog_en = wdata[eewc_pkg::BIT_PROG_EN];
            st_nxt.par_en = wdata[eewc_pkg::BIT_PAR_EN];
            if (wdata[eewc_pkg::BIT_PAR_EN] && !st_r.par_en) begin
                st_nxt.mask = 8'h00;
                st_nxt.row_valid = 1'b0;
            end
            if (!wdata[eewc_pkg::BIT_PAR_EN]) begin
                st_nxt.mask = 8'h00;
                st_nxt.row_valid = 1'b0;
            end
            // Start needs both enables already standing before this write.
            if (wdata[eewc_pkg::BIT_START] && st_r.par_en && st_r.prog_en &&
                wdata[eewc_pkg::BIT_PAR_EN] &&
                wdata[eewc_pkg::BIT_PROG_EN]) begin
                st_nxt.par_start = 1'b1;
                st_nxt.busy = 1'b1;
                st_nxt.par_cyc = 1'b1;
                st_nxt.cnt = 16'(PROG_CYCLES - 1);
                st_nxt.state = eewc_pkg::EEWC_PROG;
            end
        end
        // EEPROM writes: ignored while busy or without program enable.
        if (wr && ee_hit && !st_r.busy && st_r.prog_en) begin
            if (st_r.par_en) begin
                // Only the latched row is taken; stray rows are dropped.
                if (!st_r.row_valid || st_r.row == ee_addr[ADDR_W-1:3]) begin
                    st_nxt.row_valid = 1'b1;
                    st_nxt.row = ee_addr[ADDR_W-1:3];
                    st_nxt.lat[ee_addr[2:0]] = wdata;
                    st_nxt.mask[ee_addr[2:0]] = 1'b1;
                end
            end else begin
                st_nxt.baddr = ee_addr;
                st_nxt.bdata = wdata;
                st_nxt.busy = 1'b1;
                st_nxt.par_cyc = 1'b0;
                st_nxt.cnt = 16'(PROG_CYCLES - 1);
                st_nxt.state = eewc_pkg::EEWC_PROG;
            end
        end
        // Cycle timer; the end clears busy and the parallel bits.
        case (st_r.state)
            eewc_pkg::EEWC_IDLE: begin
            end
            eewc_pkg::EEWC_PROG: begin
                if (done) begin
                    st_nxt.state = eewc_pkg::EEWC_IDLE;
                    st_nxt.busy = 1'b0;
                    st_nxt.par_start = 1'b0;
                    if (st_r.par_cyc) begin
                        st_nxt.par_en = 1'b0;
                        st_nxt.mask = 8'h00;
                        st_nxt.row_valid = 1'b0;
                    end
                end else begin
                    st_nxt.cnt = st_r.cnt - 16'h0001;
                end
            end
            default: begin
                st_nxt.state = eewc_pkg::EEWC_IDLE;
            end
        endcase
        // Reads: one cycle, like any data read; control shows busy only.
        st_nxt.rdata = 8'h00;
        if (rd && ctrl_hit) begin
            st_nxt.rdata[eewc_pkg::BIT_BUSY] = st_r.busy;
        end else if (rd && ee_hit && !st_r.busy) begin
            st_nxt.rdata = mem[ee_addr];
        end
    end

    // State register; synchronous reset puts the control at its reset value.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_r <= '0;
            st_r.state <= eewc_pkg::EEWC_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Array update at the end of a cycle; unloaded row bytes are kept.
    always_ff @(posedge sys_clk) begin
        if (done) begin
            if (st_r.par_cyc) begin
                for (int i = 0; i < eewc_pkg::ROW_BYTES; i++) begin
                    if (st_r.mask[i]) begin
                        mem[{st_r.row, 3'(i)}] <= st_r.lat[i];
                    end
                end
            end else begin
                mem[st_r.baddr] <= st_r.bdata;
            end
        end
    end

    // Checks on the control behaviour.
    a_busy_blocks_ctrl: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr && ctrl_hit && st_r.busy && !done |=> $stable(st_r.prog_en)
        && $stable(st_r.standby))
        else $error("control changed while busy");
    a_start_needs_both: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(st_r.par_start) |-> $past(st_r.par_en) && $past(st_r.prog_en))
        else $error("start set without both enables");
    a_start_no_mode: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr && ctrl_hit && !st_r.par_en && !st_r.busy |=> !st_r.par_start)
        else $error("start set without parallel mode");
    a_end_clears_par: assert property (@(posedge sys_clk) disable iff (!rstn)
        done && st_r.par_cyc |=> !st_r.par_en && !st_r.par_start && !st_r.busy)
        else $error("parallel bits not cleared at end");
    a_mask_on_enable: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(st_r.par_en) |-> st_r.mask == 8'h00)
        else $error("row latches not cleared");
    a_row_held: assert property (@(posedge sys_clk) disable iff (!rstn)
        st_r.row_valid && st_r.par_en && !done |=> $stable(st_r.row)
        || !st_r.row_valid)
        else $error("latched row moved");
    a_no_prog_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr && ee_hit && !st_r.prog_en && !st_r.busy |=> !st_r.busy)
        else $error("write started without program enable");
    a_busy_span: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(st_r.busy) |-> st_r.busy [*8])
        else $error("busy dropped early");
    a_standby_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        rd && !ctrl_hit && st_r.standby |=> rdata == 8'h00)
        else $error("read served in stand-by");

    c_byte_write: cover property (@(posedge sys_clk) disable iff (!rstn)
        done && !st_r.par_cyc);
    c_par_write: cover property (@(posedge sys_clk) disable iff (!rstn)
        done && st_r.par_cyc && st_r.mask != 8'h00);
    c_abandon: cover property (@(posedge sys_clk) disable iff (!rstn)
        $fell(st_r.par_en) && !st_r.busy);
endmodule
`default_nettype wire

// File: hw/eewc_pkg.sv
// Package with the constants and types of the data EEPROM write control.
package eewc_pkg;
    localparam logic [7:0] CTRL_ADDR = 8'h00_DF;
    localparam logic [7:0] CTRL_RESET = 8'h00_00;
    localparam logic [7:0] WIN_LIMIT = 8'h00_40;
    localparam logic [7:0] VIRGIN = 8'h00_FF;
    localparam int BIT_STANDBY = 6;
    localparam int BIT_START = 3;
    localparam int BIT_PAR_EN = 2;
    localparam int BIT_BUSY = 1;
    localparam int BIT_PROG_EN = 0;
    localparam logic [1:0] BANK_PAGE0 = 2'h1;
    localparam logic [1:0] BANK_PAGE1 = 2'h2;
    localparam int ROW_BYTES = 8;
    localparam int PAGE_BYTES = 64;
    localparam int PAGES = 2;
    // Programming time in microseconds, a plain default for this block.
    localparam int PROG_TIME_US = 1;
    localparam int CLK_MHZ = 100;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

    typedef enum logic [1:0] {
        EEWC_IDLE = 2'b01,
        EEWC_PROG = 2'b10
    } eewc_state_t;
endpackage

// File: verif/eewc_cpu_model.sv
// Behavioural CPU core issuing data-space reads and writes.
`timescale 1ns/1ps
`default_nettype none
module eewc_cpu_model (
    input wire logic sys_clk,
    input wire logic eeprom_busy,
    input wire logic [7:0] rdata,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd
);
    // The bus starts idle with both strobes low.
    initial begin
        addr = 8'h00_00;
        wdata = 8'h00_00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // Whole-byte write only, never a single-bit access
    // Lines go inverted after the strobe so a stale value never passes.
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask

    // Read data is registered, so it is taken one cycle after the strobe.
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        addr <= ~a;
        #1 d = rdata;
    endtask

    // Busy is polled before the next access; counts the busy cycles.
    // It starts in the time step of the last strobe, so the first busy
    // cycle is counted too.
    task automatic poll(output int n);
        n = 0;
        #1;
        while (eeprom_busy === 1'b1 && n < 50) begin
            n++;
            @(posedge sys_clk);
            #1;
        end
    endtask
endmodule
`default_nettype wire

// File: verif/eewc_top_tb.sv
// Self-checking bench for the data EEPROM write control.
`timescale 1ns/1ps
`default_nettype none
module eewc_top_tb;
    localparam int PC = 8;
    localparam logic [7:0] CT = eewc_pkg::CTRL_ADDR;
    localparam logic [7:0] FF = eewc_pkg::VIRGIN;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] bank_select = eewc_pkg::BANK_PAGE0;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, eeprom_busy;
    int errors = 0;
    int n_tests = 0;
    int n;
    logic [1:0] r_bank [4] = '{2'h1, 2'h1, 2'h2, 2'h2};
    logic [7:0] r_addr [4] = '{8'h00_00, 8'h00_3F, 8'h00_07, 8'h00_3F};
    logic [7:0] r_data [4] = '{8'h00_5A, 8'h00_00, 8'h00_A5, 8'h00_C3};

    // Short count keeps the run brief; 8 is the safe minimum.
    eewc_top #(.PROG_CYCLES(PC)) eewc_top_i (.sys_clk(sys_clk),
        .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .bank_select(bank_select), .rdata(rdata),
        .eeprom_busy(eeprom_busy));
    eewc_cpu_model eewc_cpu_model_i (.sys_clk(sys_clk),
        .eeprom_busy(eeprom_busy), .rdata(rdata), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd));

    // Free-running 100 MHz clock.
    always #5 sys_clk = ~sys_clk;

    task automatic chk(input string s, input logic [7:0] e,
                       input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic w(input logic [7:0] a, input logic [7:0] d);
        eewc_cpu_model_i.wr_byte(a, d);
    endtask

    task automatic r(input logic [7:0] a, input logic [7:0] e, string s);
        logic [7:0] d;
        eewc_cpu_model_i.rd_byte(a, d);
        chk(s, e, d);
    endtask

    task automatic conclude;
        if (errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // A hang is cut short well beyond the expected run length.
    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        conclude;
    end

    // Main sequence: reset, byte-mode writes, then the awkward cases.
    initial begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        #1 chk("busy", 8'h00_00, {7'h00, eeprom_busy});
        r(CT, eewc_pkg::CTRL_RESET, "control");
        r(8'h00_10, FF, "virgin");
        w(8'h00_10, 8'h00_12);
        eewc_cpu_model_i.poll(n);
        chk("no enable", 8'h00_00, 8'(n));
        r(8'h00_10, FF, "unenabled");
        for (int i = 0; i < 4; i++) begin
            bank_select <= r_bank[i];
            w(CT, 8'h00_01);
            w(r_addr[i], r_data[i]);
            eewc_cpu_model_i.poll(n);
            chk("busy cycles", 8'(PC), 8'(n));
            r(r_addr[i], r_data[i], "byte");
        end
        bank_select <= eewc_pkg::BANK_PAGE0;
        w(8'h00_08, 8'h00_33);
        w(CT, 8'h00_40);
        w(8'h00_09, 8'h00_44);
        r(CT, 8'h00_02, "busy bit");
        eewc_cpu_model_i.poll(n);
        r(8'h00_09, FF, "busy write");
        r(8'h00_08, 8'h00_33, "completed");
        w(CT, 8'h00_41);
        r(8'h00_08, 8'h00_00, "standby");
        w(CT, 8'h00_00);
        r(8'h00_08, 8'h00_33, "awake");
        bank_select <= 2'h0;
        r(8'h00_08, 8'h00_00, "no page");
        bank_select <= eewc_pkg::BANK_PAGE0;
        w(CT, 8'h00_09);
        eewc_cpu_model_i.poll(n);
        chk("start alone", 8'h00_00, 8'(n));
        w(CT, 8'h00_0C);
        w(CT, 8'h00_0C);
        eewc_cpu_model_i.poll(n);
        chk("no enable start", 8'h00_00, 8'(n));
        w(CT, 8'h00_05);
        w(8'h00_30, 8'h00_66);
        w(CT, 8'h00_01);
        w(CT, 8'h00_05);
        w(8'h00_18, 8'h00_11);
        w(8'h00_20, 8'h00_99);
        w(8'h00_1A, 8'h00_22);
        w(8'h00_1B, 8'h00_33);
        w(CT, 8'h00_0D);
        eewc_cpu_model_i.poll(n);
        chk("parallel", 8'(PC), 8'(n));
        r(8'h00_18, 8'h00_11, "row");
        r(8'h00_1A, 8'h00_22, "row");
        r(8'h00_1B, 8'h00_33, "row");
        r(8'h00_19, FF, "unloaded");
        r(8'h00_20, FF, "other row");
        r(8'h00_30, FF, "abandoned");
        w(8'h00_28, 8'h00_55);
        eewc_cpu_model_i.poll(n);
        chk("back to byte", 8'(PC), 8'(n));
        // Reset in mid-cycle stops the timer and leaves the cell unwritten.
        w(CT, 8'h00_01);
        w(8'h00_29, 8'h00_77);
        rstn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        #1 chk("reset busy", 8'h00_00, {7'h00, eeprom_busy});
        r(CT, 8'h00_00, "reset control");
        r(8'h00_29, FF, "cut cycle");
        w(8'h00_29, 8'h00_77);
        eewc_cpu_model_i.poll(n);
        chk("reset enable", 8'h00_00, 8'(n));
        conclude;
    end
endmodule
`default_nettype wire
